// [shared/cwpr_defs.svh]
// offsets, field positions, reset values and timing counts of the config/reset block
`ifndef CWPR_DEFS_SVH
`define CWPR_DEFS_SVH
`define CWPR_ADDR_CONFIG 4'h0
`define CWPR_ADDR_OSCILLATOR_STATUS 4'h1
`define CWPR_ADDR_BORCTL 4'h2
`define CWPR_ADDR_WDTCTL 4'h3
`define CWPR_CFG_CLOCK_OUTPUT_PIN 11
`define CWPR_CFG_BOR_LO 9
`define CWPR_CFG_CP 7
`define CWPR_CFG_MASTER_RESET_PIN 6
`define CWPR_CFG_POWERUP_TIMER 5
`define CWPR_CFG_WDT_LO 3
`define CWPR_CFG_OSCILLATOR_SELECT_LO 0
`define CWPR_CFG_RSVD_MASK 14'h3104
`define CWPR_CFG_RESET 14'h3fff
`define CWPR_ST_PLL_READY_FLAG 6
`define CWPR_ST_OSC_STARTUP_STATUS 5
`define CWPR_ST_HFR 4
`define CWPR_ST_HFL 3
`define CWPR_ST_MFR 2
`define CWPR_ST_LFR 1
`define CWPR_ST_HFS 0
`define CWPR_BORCTL_SW 7
`define CWPR_BORCTL_MASK 8'h80
`define CWPR_BORCTL_RESET 8'h80
`define CWPR_WDTCTL_SW 0
`define CWPR_WDTCTL_MASK 8'h3f
`define CWPR_WDTCTL_RESET 8'h16
`define CWPR_POWERUP_TIMER_MS 64
`define CWPR_CLK_KHZ 40000
`define CWPR_POWERUP_TIMER_CYCLES (`CWPR_POWERUP_TIMER_MS * `CWPR_CLK_KHZ)
`endif

// [shared/cwpr_pkg.sv]
// types of the config/reset block
package cwpr_pkg;
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_SW    = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_ON    = 2'b11
  } cwpr_mode_e;
  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_EXT_LOW  = 2'b01,
    OSC_EXT_MED  = 2'b10,
    OSC_EXT_HIGH = 2'b11
  } cwpr_osc_e;
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_TIMER = 2'b01,
    ST_RUN   = 2'b11
  } cwpr_state_e;
endpackage : cwpr_pkg

// [core/cwpr_top.sv]
// configuration word decode, power-up timer and internal reset release
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cwpr_defs.svh"

// How it works
// R1: clock-out field 0 drives clock on pin
// R2: brown-out modes 11 on, 10 awake, 00 off
// R3: brown-out mode 01 follows software bit
// R4: code-protect 0 blocks external memory access
// R5: low-voltage programming forces reset pin, pull-up
// R6: select cleared: digital input, own pull-up
// R7: timer enable field 0 enables timer
// R8: watchdog modes 11 on, 10 awake, 00 off
// R9: watchdog mode 01 follows software bit
// R10: oscillator select decodes external modes, internal
// R11: unimplemented config bits read as one
// R12: brown-out enable leaves timer setting alone
// R13: only bulk erase removes code protection
// R14: start-up flag one on selected external clock
// R15: locked flag shows two percent accuracy
// R16: stable flag shows half percent accuracy
// R17: oscillator ready flags, low-frequency at bit1
// R18: timer lasts nominal 64 ms after reset
// R19: internal reset held while timer counts
// R20: timer starts after power and brown-out release
// R21: reset held while supply below minimum
// R22: release needs all sources idle, clock-synchronised
module cwpr_top #(
  parameter int unsigned POWERUP_TIMER_CYCLES = `CWPR_POWERUP_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  // configuration programming port
  input  wire logic        cfgProgWrite,
  input  wire logic [13:0] cfgProgData,
  input  wire logic        cfgBulkErase,
  // asynchronous analog and pin levels
  input  wire logic        porActive,
  input  wire logic        borBelowLevel,
  input  wire logic        masterResetPinLevel,
  input  wire logic        selectedClockRunning,
  input  wire logic        pllLocked,
  input  wire logic        hfOscReadyIn,
  input  wire logic        hfOscLocked2pct,
  input  wire logic        hfOscStable05pct,
  input  wire logic        mfOscReadyIn,
  input  wire logic        lfOscReadyIn,
  // same-clock controls
  input  wire logic        sleepMode,
  input  wire logic        lowVoltageProgramming,
  input  wire logic        weakPullupEnable,
  // decoded controls
  output logic             clockOutputEnable,
  output logic             brownoutResetEnable,
  output logic             watchdogEnable,
  output logic             progMemAccessAllow,
  output logic             masterResetFunction,
  output logic             resetPinPullup,
  output logic             powerupTimerEnable,
  output logic             extClockSelected,
  output logic [1:0]       extClockPowerMode,
  output logic             clockInputPinIsIo,
  // internal reset
  output logic             coreReset,
  output logic             powerupTimerActive
);

  localparam int unsigned CW = $clog2(POWERUP_TIMER_CYCLES + 1);
  localparam int unsigned NS = 10;

  // two-stage synchronisers for everything from outside this clock
  logic [NS-1:0] syncA_reg;
  logic [NS-1:0] syncB_reg;
  logic          porSync;
  logic          borSync;
  logic          mclrPinSync;
  logic          selClkSync;
  logic          pllSync;
  logic          hfReadySync;
  logic          hfLockedSync;
  logic          hfStableSync;
  logic          mfReadySync;
  logic          lfReadySync;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // first stage starts with the supply faults seen, like the second
      syncA_reg <= 10'h300;
    end else begin
      syncA_reg <= {porActive, borBelowLevel, masterResetPinLevel,
                    selectedClockRunning, pllLocked, hfOscReadyIn,
                    hfOscLocked2pct, hfOscStable05pct, mfOscReadyIn,
                    lfOscReadyIn};
    end
  end

  // power-on and brown-out are taken as active after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncB_reg <= 10'h300;
    end else begin
      syncB_reg <= syncA_reg;
    end
  end

  assign {porSync, borSync, mclrPinSync, selClkSync, pllSync, hfReadySync,
          hfLockedSync, hfStableSync, mfReadySync, lfReadySync} = syncB_reg;

  function automatic logic mode_enable(input logic [1:0] mode,
                                       input logic       swBit,
                                       input logic       asleep);
    unique case (cwpr_pkg::cwpr_mode_e'(mode))
      cwpr_pkg::MODE_ON:    mode_enable = 1'b1;
      cwpr_pkg::MODE_SLEEP: mode_enable = ~asleep;
      cwpr_pkg::MODE_SW:    mode_enable = swBit;
      cwpr_pkg::MODE_OFF:   mode_enable = 1'b0;
    endcase
  endfunction : mode_enable

  // configuration word, blank after bulk erase
  logic [13:0] cfgWord_reg;
  logic [13:0] cfgWord_next;
  logic        cpActive;

  assign cpActive = ~cfgWord_reg[`CWPR_CFG_CP];

  always_comb begin
    cfgWord_next = cfgWord_reg;
    if (cfgBulkErase) begin
      cfgWord_next = `CWPR_CFG_RESET; // R13
    end else if (cfgProgWrite) begin
      cfgWord_next = cfgProgData | `CWPR_CFG_RSVD_MASK; // R11
      // a plain write may set protection but never lift it
      if (cpActive) begin
        cfgWord_next[`CWPR_CFG_CP] = 1'b0; // R13
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfgWord_reg <= `CWPR_CFG_RESET;
    end else begin
      cfgWord_reg <= cfgWord_next;
    end
  end

  // software control registers
  logic [7:0] borCtl_reg;
  logic [7:0] wdtCtl_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      borCtl_reg <= `CWPR_BORCTL_RESET;
    end else if (regWrite && regAddr == `CWPR_ADDR_BORCTL) begin
      borCtl_reg <= regWrData[7:0] & `CWPR_BORCTL_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdtCtl_reg <= `CWPR_WDTCTL_RESET;
    end else if (regWrite && regAddr == `CWPR_ADDR_WDTCTL) begin
      wdtCtl_reg <= regWrData[7:0] & `CWPR_WDTCTL_MASK;
    end
  end

  // decode
  logic [1:0] borMode;
  logic [1:0] wdtMode;
  logic [1:0] oscSel;
  logic       borEnNext;
  logic       wdtEnNext;
  logic       mclrFuncNext;
  logic       pwrtEnNext;

  assign borMode = cfgWord_reg[`CWPR_CFG_BOR_LO +: 2];
  assign wdtMode = cfgWord_reg[`CWPR_CFG_WDT_LO +: 2];
  assign oscSel  = cfgWord_reg[`CWPR_CFG_OSCILLATOR_SELECT_LO +: 2];
  assign borEnNext = mode_enable(borMode, borCtl_reg[`CWPR_BORCTL_SW], sleepMode); // R2 R3
  assign wdtEnNext = mode_enable(wdtMode, wdtCtl_reg[`CWPR_WDTCTL_SW], sleepMode); // R8 R9
  assign mclrFuncNext = lowVoltageProgramming | cfgWord_reg[`CWPR_CFG_MASTER_RESET_PIN]; // R5 R6
  // the timer enable depends on its own field only, never on brown-out
  assign pwrtEnNext = ~cfgWord_reg[`CWPR_CFG_POWERUP_TIMER]; // R7 R12

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clockOutputEnable   <= 1'b0;
      brownoutResetEnable <= 1'b1;
      watchdogEnable      <= 1'b1;
      progMemAccessAllow  <= 1'b1;
      masterResetFunction <= 1'b1;
      resetPinPullup      <= 1'b1;
      powerupTimerEnable  <= 1'b0;
      extClockSelected    <= 1'b1;
      extClockPowerMode   <= 2'h3;
      clockInputPinIsIo   <= 1'b0;
    end else begin
      clockOutputEnable   <= ~cfgWord_reg[`CWPR_CFG_CLOCK_OUTPUT_PIN]; // R1
      brownoutResetEnable <= borEnNext;
      watchdogEnable      <= wdtEnNext;
      progMemAccessAllow  <= ~cpActive; // R4
      masterResetFunction <= mclrFuncNext;
      resetPinPullup      <= mclrFuncNext | weakPullupEnable; // R5 R6
      powerupTimerEnable  <= pwrtEnNext;
      extClockSelected    <= oscSel != cwpr_pkg::OSC_INTERNAL; // R10
      extClockPowerMode   <= oscSel; // R10
      clockInputPinIsIo   <= oscSel == cwpr_pkg::OSC_INTERNAL; // R10
    end
  end

  // oscillator status, read-only
  logic [7:0] oscillator_status;

  always_comb begin
    oscillator_status = 8'h00;
    oscillator_status[`CWPR_ST_PLL_READY_FLAG] = pllSync;
    oscillator_status[`CWPR_ST_OSC_STARTUP_STATUS] = selClkSync && oscSel != cwpr_pkg::OSC_INTERNAL; // R14
    oscillator_status[`CWPR_ST_HFR]  = hfReadySync; // R17
    oscillator_status[`CWPR_ST_HFL]  = hfLockedSync; // R15
    oscillator_status[`CWPR_ST_MFR]  = mfReadySync; // R17
    oscillator_status[`CWPR_ST_LFR]  = lfReadySync; // R17
    oscillator_status[`CWPR_ST_HFS]  = hfStableSync; // R16
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        `CWPR_ADDR_CONFIG:  regRdData <= {2'h0, cfgWord_reg | `CWPR_CFG_RSVD_MASK}; // R11
        `CWPR_ADDR_OSCILLATOR_STATUS: regRdData <= {8'h00, oscillator_status};
        `CWPR_ADDR_BORCTL:  regRdData <= {8'h00, borCtl_reg};
        `CWPR_ADDR_WDTCTL:  regRdData <= {8'h00, wdtCtl_reg};
        default:            regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // reset sequencer
  cwpr_pkg::cwpr_state_e state_reg;
  logic [CW-1:0]         pwrtCount_reg;
  logic                  timerArmed_reg;
  logic                  supplyFault;
  logic                  pinReset;
  logic                  anyReset;
  logic                  timerDone;

  assign supplyFault = porSync | (borEnNext & borSync);
  assign pinReset    = mclrFuncNext & ~mclrPinSync;
  assign anyReset    = supplyFault | pinReset;
  assign timerDone   = pwrtCount_reg == CW'(POWERUP_TIMER_CYCLES - 1);

  // a supply fault arms the timer; a pin reset alone does not
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timerArmed_reg <= 1'b1;
    end else if (supplyFault) begin
      timerArmed_reg <= 1'b1; // R18
    end else if (state_reg == cwpr_pkg::ST_RUN || state_reg == cwpr_pkg::ST_TIMER) begin
      timerArmed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= cwpr_pkg::ST_HOLD;
    end else begin
      unique case (state_reg)
        cwpr_pkg::ST_HOLD: begin
          if (!anyReset) begin // R20 R22
            if (timerArmed_reg && pwrtEnNext) begin
              state_reg <= cwpr_pkg::ST_TIMER;
            end else begin
              state_reg <= cwpr_pkg::ST_RUN;
            end
          end
        end
        cwpr_pkg::ST_TIMER: begin
          if (anyReset) begin
            state_reg <= cwpr_pkg::ST_HOLD; // R21
          end else if (timerDone) begin
            state_reg <= cwpr_pkg::ST_RUN;
          end
        end
        cwpr_pkg::ST_RUN: begin
          if (anyReset) begin
            state_reg <= cwpr_pkg::ST_HOLD; // R21
          end
        end
        default: state_reg <= cwpr_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwrtCount_reg <= '0;
    end else if (state_reg == cwpr_pkg::ST_TIMER && !anyReset) begin
      pwrtCount_reg <= pwrtCount_reg + CW'(1); // R18
    end else begin
      pwrtCount_reg <= '0;
    end
  end

  // release follows the registered state, so it lines up with clk_sys
  assign coreReset          = state_reg != cwpr_pkg::ST_RUN; // R19 R22
  assign powerupTimerActive = state_reg == cwpr_pkg::ST_TIMER;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_supplyGood;
    !supplyFault && !pinReset;
  endsequence

  sequence s_timerRun;
    powerupTimerActive && !anyReset;
  endsequence

  property p_clock_output_pin;
    1'b1 |=> clockOutputEnable == !$past(cfgWord_reg[`CWPR_CFG_CLOCK_OUTPUT_PIN]);
  endproperty
  a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock out enable wrong"); // R1

  property p_borMode;
    1'b1 |=> brownoutResetEnable == ($past(borMode) == 2'h3 ||
      ($past(borMode) == 2'h2 && !$past(sleepMode)) ||
      ($past(borMode) == 2'h1 && $past(borCtl_reg[`CWPR_BORCTL_SW])));
  endproperty
  a_borMode: assert property (p_borMode) else $error("brown-out mode wrong"); // R2

  property p_wdtSw;
    wdtMode == 2'h1 |=> watchdogEnable == $past(wdtCtl_reg[`CWPR_WDTCTL_SW]);
  endproperty
  a_wdtSw: assert property (p_wdtSw) else $error("watchdog software mode wrong"); // R9

  property p_cpLock;
    cpActive && !cfgBulkErase |=> cpActive;
  endproperty
  a_cpLock: assert property (p_cpLock) else $error("code protect lifted"); // R13

  property p_cfgRsvd;
    regRead && regAddr == `CWPR_ADDR_CONFIG |=> regRdData[13:12] == 2'h3
      && regRdData[8] && regRdData[2];
  endproperty
  a_cfgRsvd: assert property (p_cfgRsvd) else $error("reserved bits not one"); // R11

  property p_lvpPin;
    lowVoltageProgramming |=> masterResetFunction && resetPinPullup;
  endproperty
  a_lvpPin: assert property (p_lvpPin) else $error("reset pin not forced"); // R5

  property p_porHold;
    porSync |=> coreReset;
  endproperty
  a_porHold: assert property (p_porHold) else $error("reset released under fault"); // R21

  property p_timerHold;
    powerupTimerActive |-> coreReset;
  endproperty
  a_timerHold: assert property (p_timerHold) else $error("reset low while timing"); // R19

  property p_timerEnd;
    s_timerRun ##0 timerDone |=> !coreReset;
  endproperty
  a_timerEnd: assert property (p_timerEnd) else $error("timer end no release"); // R18

  property p_timerStart;
    $rose(powerupTimerActive) |-> !$past(supplyFault) && pwrtCount_reg == '0;
  endproperty
  a_timerStart: assert property (p_timerStart) else $error("timer began under fault"); // R20

  property p_release;
    $fell(coreReset) |-> !$past(supplyFault) && !$past(pinReset) && !anyReset;
  endproperty
  a_release: assert property (p_release) else $error("release with a source active"); // R22

  property p_runNoTimer;
    state_reg == cwpr_pkg::ST_HOLD && !timerArmed_reg ##0 s_supplyGood
      |=> !coreReset;
  endproperty
  a_runNoTimer: assert property (p_runNoTimer) else $error("pin reset not released"); // R22

endmodule : cwpr_top
`default_nettype wire

// [verif/cwpr_core_model.sv]
// consumer-side model of the core: tracks how long it is held in reset
`timescale 1ns/100ps
`default_nettype none
module cwpr_core_model (
  // clock
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // reset from the block
  input  wire logic        coreReset,
  input  wire logic        powerupTimerActive,
  // observations
  output logic             badSeen,
  output logic [15:0]      heldCycles
);
  // the core must never run while the timer still counts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      badSeen    <= 1'b0;
      heldCycles <= 16'h0000;
    end else begin
      if (powerupTimerActive && !coreReset) badSeen <= 1'b1;
      heldCycles <= coreReset ? heldCycles + 16'h0001 : 16'h0000;
    end
  end
endmodule : cwpr_core_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the config word and reset release block
`timescale 1ns/100ps
`default_nettype none
`include "cwpr_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  localparam int unsigned NPW = 16;
  logic        clk_sys = 1'b0, rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000, regRdData, d;
  logic        regWrite = 1'b0, regRead = 1'b0;
  logic        cfgProgWrite = 1'b0, cfgBulkErase = 1'b0;
  logic [13:0] cfgProgData = 14'h0000;
  logic        porActive = 1'b1, borBelowLevel = 1'b0, pinLevel = 1'b1;
  logic [6:0]  oscIn = 7'h00;
  logic        sleepMode = 1'b0, low_voltage_programming = 1'b0, weak_pullup_enable = 1'b0;
  logic        clock_output_pin, brownout_enable_mode, wdtEn, memAllow, mrFunc, pinPull, pwrtEn, extSel, pinIo;
  logic [1:0]  extMode;
  logic        coreReset, timerActive, badSeen;
  logic [15:0] heldCycles;
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
  always #12.5 clk_sys = ~clk_sys;
  cwpr_top #(.POWERUP_TIMER_CYCLES(NPW)) dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .cfgProgWrite(cfgProgWrite), .cfgProgData(cfgProgData), .cfgBulkErase(cfgBulkErase),
    .porActive(porActive), .borBelowLevel(borBelowLevel), .masterResetPinLevel(pinLevel),
    .selectedClockRunning(oscIn[5]), .pllLocked(oscIn[6]), .hfOscReadyIn(oscIn[4]),
    .hfOscLocked2pct(oscIn[3]), .hfOscStable05pct(oscIn[0]), .mfOscReadyIn(oscIn[2]),
    .lfOscReadyIn(oscIn[1]), .sleepMode(sleepMode), .lowVoltageProgramming(low_voltage_programming),
    .weakPullupEnable(weak_pullup_enable), .clockOutputEnable(clock_output_pin), .brownoutResetEnable(brownout_enable_mode),
    .watchdogEnable(wdtEn), .progMemAccessAllow(memAllow), .masterResetFunction(mrFunc),
    .resetPinPullup(pinPull), .powerupTimerEnable(pwrtEn), .extClockSelected(extSel),
    .extClockPowerMode(extMode), .clockInputPinIsIo(pinIo), .coreReset(coreReset),
    .powerupTimerActive(timerActive));
  cwpr_core_model core (.clk_sys(clk_sys), .rst(rst), .coreReset(coreReset),
    .powerupTimerActive(timerActive), .badSeen(badSeen), .heldCycles(heldCycles));
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWrite  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    v = regRdData;
  endtask : rd
  task automatic prog(input logic [13:0] v, input logic erase);
    @(posedge clk_sys);
    cfgProgWrite <= ~erase;
    cfgBulkErase <= erase;
    cfgProgData  <= v;
    @(posedge clk_sys);
    cfgProgWrite <= 1'b0;
    cfgBulkErase <= 1'b0;
    tick(3);
  endtask : prog
  function automatic logic mode_on(input logic [1:0] m, input logic sw, input logic s);
    return (m == 2'b11) || (m == 2'b10 && !s) || (m == 2'b01 && sw);
  endfunction : mode_on
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // generous ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    tick(5);
    rst <= 1'b0;
    tick(6);
    `CHK(coreReset, 1'b1)
    porActive <= 1'b0;
    tick(6);
    `CHK(coreReset, 1'b0)
    `CHK(pwrtEn, 1'b0)
    rd(`CWPR_ADDR_CONFIG, d); `CHK(d, 16'h3fff)
    rd(`CWPR_ADDR_BORCTL, d); `CHK(d, 16'h0080)
    rd(`CWPR_ADDR_WDTCTL, d); `CHK(d, 16'h0016)
    rd(4'h4, d); `CHK(d, 16'h0000)
    wr(`CWPR_ADDR_WDTCTL, 16'hffff); rd(`CWPR_ADDR_WDTCTL, d); `CHK(d, 16'h003f)
    wr(`CWPR_ADDR_CONFIG, 16'h0000); rd(`CWPR_ADDR_CONFIG, d); `CHK(d, 16'h3fff)
    for (int m = 0; m < 4; m++)
      for (int sw = 0; sw < 2; sw++)
        for (int s = 0; s < 2; s++) begin
          prog({3'b111, 2'(m), 4'b1111, 2'(m), 3'b111}, 1'b0);
          wr(`CWPR_ADDR_BORCTL, {8'h00, 1'(sw), 7'h00});
          wr(`CWPR_ADDR_WDTCTL, {8'h00, 2'b00, 5'h0b, 1'(sw)});
          sleepMode <= 1'(s);
          tick(3);
          `CHK(brownout_enable_mode, mode_on(2'(m), 1'(sw), 1'(s)))
          `CHK(wdtEn, mode_on(2'(m), 1'(sw), 1'(s)))
        end
    sleepMode <= 1'b0;
    // ends on the internal oscillator so the start-up flag must read 0 next
    for (int o = 3; o >= 0; o--) begin
      prog(14'h3ffc | 14'(o), 1'b0);
      `CHK(extSel, (o != 0))
      `CHK(extMode, 2'(o))
      `CHK(pinIo, (o == 0))
      `CHK(clock_output_pin, 1'b0)
    end
    oscIn <= 7'h20;
    tick(5);
    rd(`CWPR_ADDR_OSCILLATOR_STATUS, d); `CHK(d, 16'h0000)
    prog(14'h3fff, 1'b0);
    // one flag at a time so a swapped bit position shows up
    for (int i = 0; i < 7; i++) begin
      oscIn <= 7'(1 << i);
      tick(5);
      rd(`CWPR_ADDR_OSCILLATOR_STATUS, d); `CHK(d, 16'(1 << i))
    end
    oscIn <= 7'h00;
    prog(14'h37df, 1'b0);
    `CHK(clock_output_pin, 1'b1)
    `CHK(pwrtEn, 1'b1)
    prog(14'h0000, 1'b0);
    rd(`CWPR_ADDR_CONFIG, d); `CHK(d, 16'h3104)
    `CHK(memAllow, 1'b0)
    prog(14'h3fff, 1'b0);
    rd(`CWPR_ADDR_CONFIG, d); `CHK(d, 16'h3f7f)
    prog(14'h0000, 1'b1);
    rd(`CWPR_ADDR_CONFIG, d); `CHK(d, 16'h3fff)
    `CHK(memAllow, 1'b1)
    prog(14'h3fbf, 1'b0);
    low_voltage_programming <= 1'b1;
    tick(3);
    `CHK(mrFunc, 1'b1)
    `CHK(pinPull, 1'b1)
    low_voltage_programming <= 1'b0;
    pinLevel <= 1'b0;
    tick(6);
    `CHK(mrFunc, 1'b0)
    `CHK(pinPull, 1'b0)
    `CHK(coreReset, 1'b0)
    weak_pullup_enable <= 1'b1;
    tick(3);
    `CHK(pinPull, 1'b1)
    pinLevel <= 1'b1;
    prog(14'h3fff, 1'b0);
    pinLevel <= 1'b0;
    tick(6);
    `CHK(coreReset, 1'b1)
    `CHK(heldCycles, 16'h0003)
    pinLevel <= 1'b1;
    tick(6);
    `CHK(coreReset, 1'b0)
    prog(14'h3fdf, 1'b0);
    porActive <= 1'b1;
    borBelowLevel <= 1'b1;
    tick(6);
    porActive <= 1'b0;
    tick(12);
    `CHK(timerActive, 1'b0)
    `CHK(coreReset, 1'b1)
    borBelowLevel <= 1'b0;
    n = 0;
    while (timerActive !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    while (timerActive === 1'b1 && n < 100) begin
      `CHK(coreReset, 1'b1)
      tick(1);
      n++;
    end
    `CHK(n, NPW)
    `CHK(coreReset, 1'b0)
    `CHK(badSeen, 1'b0)
    end_sim();
  end
endmodule : tb
`default_nettype wire
